// File: design/spi_port_pkg.sv
// Purpose: Constants for the serial port control block
// Assumes: 8-bit registers on a plain strobe port
// Notes:   Offsets and reset values named once here
`default_nettype none
package spi_port_pkg;
    // Register map (word index on the plain port)
    localparam logic [1:0] CTRL_ADDR    = 2'h0;
    localparam logic [1:0] STATCTL_ADDR = 2'h1;
    localparam logic [1:0] DATA_ADDR    = 2'h2;
    localparam logic [1:0] BREAK_ADDR   = 2'h3;
    // Control register fields
    localparam int RXIE_BIT = 7;
    localparam int MSTR_BIT = 5;
    localparam int CLOCK_POLARITY_BIT = 4;
    localparam int CLOCK_PHASE_BIT = 3;
    localparam int WOM_BIT  = 2;
    localparam int EN_BIT   = 1;
    localparam int TXIE_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h28;
    localparam logic [7:0] CTRL_MASK  = 8'hBF;
    // Status/control register fields
    localparam int RXF_BIT   = 7;
    localparam int ERROR_IRQ_ENABLE_BIT = 6;
    localparam int OVR_BIT   = 5;
    localparam int MODE_FAULT_FLAG_BIT  = 4;
    localparam int TXE_BIT   = 3;
    localparam int MFEN_BIT  = 2;
    localparam int BAUD_HI   = 1;
    localparam logic [7:0] STAT_RESET = 8'h08;
    localparam logic [7:0] STAT_WMASK = 8'h47;
    // Bit count per byte
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage : spi_port_pkg
`default_nettype wire

// File: design/spi_port.sv
// Purpose: Serial peripheral port: control, pin steering, break, stop
// Assumes: Single clock; pins pass a 3-stage synchroniser
// Notes:   Slave clock edges are detected in the bus clock domain
`default_nettype none

module spi_port
    import spi_port_pkg::*;
(
    // Clock, reset, enable
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       ce_in,
    // System state
    input  wire logic       stop_mode_in,
    input  wire logic       break_in,
    // Register port
    input  wire logic [1:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    // Interrupt requests
    output logic            tx_irq_out,
    output logic            rx_err_irq_out,
    // Pins: input, output, enable (low = driving)
    input  wire logic       miso_in,
    output logic            miso_out,
    output logic            miso_oe_n_out,
    input  wire logic       mosi_in,
    output logic            mosi_out,
    output logic            mosi_oe_n_out,
    input  wire logic       sclk_in,
    output logic            sclk_out,
    output logic            sclk_oe_n_out,
    input  wire logic       ss_n_in,
    // Pin ownership: high when port takes the pin from GPIO
    output logic            pins_owned_out,
    output logic            ss_owned_out
);
    typedef enum {ST_IDLE, ST_ACTIVE} xfer_t;

    // Synchronisers: one three-stage chain per pin, select idles high
    localparam logic [3:0] PIN_IDLE = 4'h8;
    logic [3:0] pin_raw;
    logic [2:0] sync_r [4];
    logic [2:0] miso_s_r, mosi_s_r, sclk_s_r, ss_s_r;
    logic       sclk_q_r, ss_q_r;
    assign pin_raw = {ss_n_in, sclk_in, mosi_in, miso_in};
    for (genvar i = 0; i < 4; i++) begin : g_sync
        always_ff @(posedge clk_in) begin
            if (rst_in) begin
                sync_r[i] <= {3{PIN_IDLE[i]}};
            end else if (ce_in) begin
                sync_r[i] <= {sync_r[i][1:0], pin_raw[i]};
            end
        end
    end
    assign miso_s_r = sync_r[0];
    assign mosi_s_r = sync_r[1];
    assign sclk_s_r = sync_r[2];
    assign ss_s_r   = sync_r[3];

    // Filtered levels move only when second and third stages agree,
    // so a one-cycle glitch on a pin never becomes an edge
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sclk_q_r <= 1'b0;
            ss_q_r   <= 1'b1;
        end else if (ce_in) begin
            if (sclk_s_r[1] == sclk_s_r[2])
                sclk_q_r <= sclk_s_r[2];
            if (ss_s_r[1] == ss_s_r[2])
                ss_q_r <= ss_s_r[2];
        end
    end

    // Registers
    logic [7:0] ctrl_r, stat_r, tx_buf_r, rx_buf_r, shift_r;
    logic       break_clear_enable_r, mode_fault_flag_step1_r, rx_step1_r;
    logic [6:0] div_r;
    logic [3:0] bit_cnt_r;
    logic       sck_r, sample_r;
    xfer_t      st_r;

    logic run, en, mstr, clock_polarity, clock_phase, mfen, clr_ok, sel;
    assign run    = ce_in && !stop_mode_in;
    assign en     = ctrl_r[EN_BIT];
    assign mstr   = ctrl_r[MSTR_BIT];
    assign clock_polarity   = ctrl_r[CLOCK_POLARITY_BIT];
    assign clock_phase   = ctrl_r[CLOCK_PHASE_BIT];
    assign mfen   = stat_r[MFEN_BIT];
    assign clr_ok = !break_in || break_clear_enable_r;
    assign sel    = en && !mstr && !ss_q_r;

    // Divider select and edges
    logic [6:0] div_top;
    always_comb begin
        case (stat_r[BAUD_HI:0])
            2'h0:    div_top = 7'h00;
            2'h1:    div_top = 7'h03;
            2'h2:    div_top = 7'h0F;
            default: div_top = 7'h3F;
        endcase
    end
    logic half_tick;
    assign half_tick = (div_r == div_top);

    logic s_rise, s_fall, s_lead, s_trail, ss_fall;
    assign s_rise  = sclk_s_r[2] && sclk_s_r[1] && !sclk_q_r;
    assign s_fall  = !sclk_s_r[2] && !sclk_s_r[1] && sclk_q_r;
    assign s_lead  = sel && (clock_polarity ? s_fall : s_rise);
    assign s_trail = sel && (clock_polarity ? s_rise : s_fall);
    assign ss_fall = !ss_s_r[2] && !ss_s_r[1] && ss_q_r;

    // Mode fault causes
    // Gated by run so a select edge during stop cannot fault
    logic m_fault, s_fault;
    assign m_fault = run && en && mstr && mfen && !ss_q_r;
    assign s_fault = run && en && !mstr && mfen && st_r == ST_ACTIVE
                     && ss_s_r[2] && ss_s_r[1] && !ss_q_r;

    logic ctrl_wr, stat_rd, data_rd, data_wr;
    assign ctrl_wr = wr_in && addr_in == CTRL_ADDR;
    assign stat_rd = rd_in && addr_in == STATCTL_ADDR;
    assign data_rd = rd_in && addr_in == DATA_ADDR;
    assign data_wr = wr_in && addr_in == DATA_ADDR;

    // Transfer engine
    logic byte_done, load_tx;
    assign byte_done = st_r == ST_ACTIVE && bit_cnt_r == BITS_PER_BYTE;
    assign load_tx = en && !stat_r[TXE_BIT] && st_r == ST_IDLE
                     && (mstr || (clock_phase ? s_lead : ss_fall) || byte_done);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_r      <= ST_IDLE;
            bit_cnt_r <= 4'h0;
            div_r     <= 7'h00;
            sck_r     <= 1'b0;
            sample_r  <= 1'b0;
            shift_r   <= 8'h00;
        end else if (run) begin
            if (!en || m_fault) begin
                st_r      <= ST_IDLE;
                bit_cnt_r <= 4'h0;
                div_r     <= 7'h00;
                sck_r     <= 1'b0;
            end else if (byte_done) begin
                st_r      <= ST_IDLE;
                bit_cnt_r <= 4'h0;
                sck_r     <= 1'b0;
            end else if (st_r == ST_IDLE) begin
                div_r <= 7'h00;
                if (load_tx || (!mstr && sel && clock_phase && s_lead)) begin
                    st_r    <= ST_ACTIVE;
                    shift_r <= load_tx ? tx_buf_r : shift_r;
                    if (!mstr && clock_phase) begin
                        sck_r    <= 1'b1;
                        sample_r <= mosi_s_r[2];
                    end
                end
            end else if (mstr) begin
                div_r <= half_tick ? 7'h00 : div_r + 7'h01;
                if (half_tick) begin
                    sck_r <= !sck_r;
                    if (sck_r == clock_phase) begin
                        sample_r <= miso_s_r[2];
                    end else begin
                        shift_r   <= {shift_r[6:0], sample_r};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                end
            end else if (!ss_q_r) begin
                if (clock_phase ? s_trail : s_lead)
                    sample_r <= mosi_s_r[2];
                if (clock_phase ? s_lead : s_trail) begin
                    shift_r   <= {shift_r[6:0], sample_r};
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                end
                if (clock_phase && s_trail && bit_cnt_r == 4'h7) begin
                    shift_r   <= {shift_r[6:0], mosi_s_r[2]};
                    bit_cnt_r <= BITS_PER_BYTE;
                end
            end
        end
    end

    // Control register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctrl_r <= CTRL_RESET;
        end else if (run) begin
            if (ctrl_wr)
                ctrl_r <= wdata_in & CTRL_MASK;
            if (m_fault)
                ctrl_r[EN_BIT] <= 1'b0;
        end
    end

    // Status flags; set wins over clear
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            stat_r       <= STAT_RESET;
            tx_buf_r     <= 8'h00;
            rx_buf_r     <= 8'h00;
            mode_fault_flag_step1_r <= 1'b0;
            rx_step1_r   <= 1'b0;
            break_clear_enable_r       <= 1'b0;
        end else if (run) begin
            if (wr_in && addr_in == STATCTL_ADDR)
                stat_r <= (stat_r & ~STAT_WMASK)
                          | (wdata_in & STAT_WMASK);
            if (wr_in && addr_in == BREAK_ADDR)
                break_clear_enable_r <= wdata_in[7];
            // First clear steps; held through break
            if (stat_rd && clr_ok) begin
                mode_fault_flag_step1_r <= stat_r[MODE_FAULT_FLAG_BIT];
                rx_step1_r   <= stat_r[RXF_BIT] | stat_r[OVR_BIT];
            end
            if (ctrl_wr && mode_fault_flag_step1_r && clr_ok
                && !m_fault && !s_fault) begin
                stat_r[MODE_FAULT_FLAG_BIT] <= 1'b0;
                mode_fault_flag_step1_r     <= 1'b0;
            end
            if (data_rd && rx_step1_r && clr_ok) begin
                stat_r[RXF_BIT] <= 1'b0;
                stat_r[OVR_BIT] <= 1'b0;
                rx_step1_r      <= 1'b0;
            end
            if (data_wr) begin
                tx_buf_r <= wdata_in;
                if (clr_ok)
                    stat_r[TXE_BIT] <= 1'b0;
            end
            if (load_tx)
                stat_r[TXE_BIT] <= 1'b1;
            if (byte_done && en) begin
                if (stat_r[RXF_BIT]) begin
                    stat_r[OVR_BIT] <= 1'b1;
                end else begin
                    rx_buf_r        <= shift_r;
                    stat_r[RXF_BIT] <= 1'b1;
                end
            end
            if (m_fault || s_fault)
                stat_r[MODE_FAULT_FLAG_BIT] <= 1'b1;
            if (m_fault || !en)
                stat_r[TXE_BIT] <= 1'b1;
        end
    end

    // Read data: always the addressed register, one cycle later
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_out <= 8'h00;
        end else if (ce_in) begin
            case (addr_in)
                CTRL_ADDR:    rdata_out <= ctrl_r;
                STATCTL_ADDR: rdata_out <= stat_r;
                DATA_ADDR:    rdata_out <= rx_buf_r;
                default:      rdata_out <= {break_clear_enable_r, 7'h00};
            endcase
        end
    end

    // Interrupt levels keep updating in stop so a request can wake
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tx_irq_out     <= 1'b0;
            rx_err_irq_out <= 1'b0;
        end else if (ce_in) begin
            tx_irq_out     <= ctrl_r[TXIE_BIT] && en
                              && stat_r[TXE_BIT];
            rx_err_irq_out <= (ctrl_r[RXIE_BIT] && stat_r[RXF_BIT])
                              || (stat_r[ERROR_IRQ_ENABLE_BIT]
                              && (stat_r[MODE_FAULT_FLAG_BIT]
                              || stat_r[OVR_BIT]));
        end
    end

    // Pin steering; a master mode fault hands every pin back in the same cycle
    logic ms_drv, own;
    assign own    = en && !m_fault;
    assign ms_drv = own && mstr;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            miso_out       <= 1'b1;
            miso_oe_n_out  <= 1'b1;
            mosi_out       <= 1'b1;
            mosi_oe_n_out  <= 1'b1;
            sclk_out       <= 1'b0;
            sclk_oe_n_out  <= 1'b1;
            pins_owned_out <= 1'b0;
            ss_owned_out   <= 1'b0;
        end else if (ce_in) begin
            pins_owned_out <= own;
            ss_owned_out   <= own && (!mstr || mfen);
            // Open-drain drives only low
            mosi_out <= shift_r[7];
            miso_out <= shift_r[7];
            sclk_out <= clock_polarity ^ sck_r;
            mosi_oe_n_out <= !(ms_drv && !(ctrl_r[WOM_BIT]
                              && shift_r[7]));
            sclk_oe_n_out <= !(ms_drv && !(ctrl_r[WOM_BIT]
                              && (clock_polarity ^ sck_r)));
            miso_oe_n_out <= !(sel && !(ctrl_r[WOM_BIT]
                              && shift_r[7]));
        end
    end
endmodule : spi_port
`default_nettype wire

// File: test/spi_port_sva.sv
// Purpose: Port-level checks for the serial port control block
// Assumes: Synchronous active-high reset, one clock
// Notes:   Select pin passes a synchroniser, so waits have margin
`default_nettype none
module spi_port_sva
    import spi_port_pkg::*;
(
    // Clock, reset, register port
    input wire logic       clk_in,
    input wire logic       rst_in,
    input wire logic       ce_in,
    input wire logic       stop_mode_in,
    input wire logic [1:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic [7:0] rdata_out,
    // Pins and ownership
    input wire logic       miso_oe_n_out,
    input wire logic       sclk_oe_n_out,
    input wire logic       ss_n_in,
    input wire logic       pins_owned_out,
    input wire logic       ss_owned_out
);
    logic ctl_wr;
    assign ctl_wr = wr_in && ce_in && !stop_mode_in && addr_in == CTRL_ADDR;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    reset_state_a: assert property ($fell(rst_in) |-> miso_oe_n_out
        && sclk_oe_n_out && !pins_owned_out && rdata_out == 8'h00)
        else $error("outputs not at reset level");
    disable_release_a: assert property (ctl_wr && !wdata_in[EN_BIT]
        |-> ##2 !pins_owned_out && !ss_owned_out)
        else $error("disabled port still owns pins");
    enable_owns_a: assert property (ss_n_in [*4] ##0 ctl_wr
        && wdata_in[EN_BIT] && wdata_in[MSTR_BIT] |-> ##2 pins_owned_out)
        else $error("enabled master does not own pins");
    unused_bit_a: assert property (rd_in && ce_in
        && addr_in == CTRL_ADDR |=> rdata_out[6] == 1'b0)
        else $error("unused control bit reads one");
    select_owner_a: assert property (ss_owned_out |-> pins_owned_out)
        else $error("select owned by a disabled port");
    miso_slave_a: assert property (!miso_oe_n_out
        |-> pins_owned_out && sclk_oe_n_out)
        else $error("miso driven outside slave role");
    miso_release_a: assert property (ss_n_in [*8] |-> miso_oe_n_out)
        else $error("deselected slave drives miso");
    stop_hold_a: assert property (stop_mode_in [*4]
        |-> $stable(pins_owned_out))
        else $error("pin ownership moved in stop");

    cover property (ctl_wr && wdata_in[EN_BIT]);
    cover property (!miso_oe_n_out);
    cover property (stop_mode_in [*4]);
endmodule : spi_port_sva

bind spi_port spi_port_sva spi_port_sva_i (.clk_in(clk_in),
    .rst_in(rst_in), .ce_in(ce_in), .stop_mode_in(stop_mode_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .miso_oe_n_out(miso_oe_n_out),
    .sclk_oe_n_out(sclk_oe_n_out), .ss_n_in(ss_n_in),
    .pins_owned_out(pins_owned_out), .ss_owned_out(ss_owned_out));
`default_nettype wire

// File: test/spi_far_master.sv
// Purpose: Far-end serial master that selects and clocks the port
// Assumes: Clock polarity 0, phase 1 framing
// Notes:   Released lines toggle every cycle, never hold a value
`default_nettype none
module spi_far_master (
    // Clock and bench requests
    input  wire logic clk_in,
    input  wire logic sel_in,
    input  wire logic go_in,
    // Lines toward the port
    output logic      ss_n_out,
    output logic      sclk_out,
    output logic      mosi_out,
    output logic      float_out
);
    logic [7:0] cnt_r  = 8'h00;
    logic       tog_r  = 1'b0;
    logic       ss_n_r = 1'b1;

    // Bench decides framing; phase 0 needs a toggle per byte
    always_ff @(posedge clk_in) begin
        ss_n_r <= ~sel_in;
    end
    // 16 bus cycles per serial clock, eight clocks per byte
    always_ff @(posedge clk_in) begin
        if (go_in) begin
            cnt_r <= 8'h80;
        end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end
    always_ff @(posedge clk_in) begin
        tog_r <= ~tog_r;
    end

    assign ss_n_out  = ss_n_r;
    assign sclk_out  = cnt_r[3];
    assign mosi_out  = (cnt_r != 8'h00) ? cnt_r[4] : tog_r;
    assign float_out = tog_r;
endmodule : spi_far_master
`default_nettype wire

// File: test/testbench.sv
// Purpose: Self-checking bench for the serial port control block
// Assumes: ce_in held high; far end is a byte-clocking master
// Notes:   Expected values follow the control and status layout
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
    n_mismatch++; $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
    end end
module testbench
    import spi_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk_in, rst_in = 1'b1, ce_in = 1'b1;
    logic       stop_mode_in = 1'b0, break_in = 1'b0;
    logic [1:0] addr_in = 2'h0;
    logic [7:0] wdata_in = 8'h00, rdata_out;
    logic       wr_in = 1'b0, rd_in = 1'b0, sel = 1'b0, go = 1'b0;
    logic       miso_in, miso_out, miso_oe_n_out, mosi_in, mosi_out;
    logic       mosi_oe_n_out, sclk_in, sclk_out, sclk_oe_n_out, ss_n_in;
    logic       pins_owned_out, ss_owned_out, f_sclk, f_mosi, f_float;
    logic       tx_irq, rx_irq;
    int         n_mismatch = 0, check_count = 0;

    // Each shared line takes the level of whoever enables a driver
    assign miso_in = miso_oe_n_out ? f_float : miso_out;
    assign mosi_in = mosi_oe_n_out ? f_mosi : mosi_out;
    assign sclk_in = sclk_oe_n_out ? f_sclk : sclk_out;

    spi_port spi_port_i (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .stop_mode_in(stop_mode_in), .break_in(break_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .tx_irq_out(tx_irq),
        .rx_err_irq_out(rx_irq), .miso_in(miso_in), .miso_out(miso_out),
        .miso_oe_n_out(miso_oe_n_out), .mosi_in(mosi_in),
        .mosi_out(mosi_out), .mosi_oe_n_out(mosi_oe_n_out),
        .sclk_in(sclk_in), .sclk_out(sclk_out),
        .sclk_oe_n_out(sclk_oe_n_out), .ss_n_in(ss_n_in),
        .pins_owned_out(pins_owned_out), .ss_owned_out(ss_owned_out));
    spi_far_master spi_far_master_i (.clk_in(clk_in), .sel_in(sel),
        .go_in(go), .ss_n_out(ss_n_in), .sclk_out(f_sclk),
        .mosi_out(f_mosi), .float_out(f_float));

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a, input logic [7:0] ex,
                      input string nm);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        @(posedge clk_in);
        `CHK(nm, ex, rdata_out)
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(posedge clk_in);
    endtask : settle

    task automatic clock_byte;
        @(posedge clk_in);
        go <= 1'b1;
        @(posedge clk_in);
        go <= 1'b0;
        settle(140);
    endtask : clock_byte

    initial begin
        settle(10);
        rst_in <= 1'b0;
        rd(CTRL_ADDR, CTRL_RESET, "ctrl reset");
        rd(STATCTL_ADDR, STAT_RESET, "stat reset");
        wr(CTRL_ADDR, 8'hFF);
        rd(CTRL_ADDR, 8'hBF, "ctrl unused");
        `CHK("tx irq", 1'b1, tx_irq)
        `CHK("rx irq", 1'b0, rx_irq)
        stop_mode_in <= 1'b1;
        wr(CTRL_ADDR, 8'h00);
        rd(CTRL_ADDR, 8'hBF, "ctrl in stop");
        stop_mode_in <= 1'b0;
        wr(CTRL_ADDR, 8'h0A);
        wr(STATCTL_ADDR, 8'h00);
        sel <= 1'b1;
        settle(8);
        `CHK("miso drive", 1'b0, miso_oe_n_out)
        `CHK("ss slave", 1'b1, ss_owned_out)
        `CHK("sclk input", 1'b1, sclk_oe_n_out)
        sel <= 1'b0;
        settle(8);
        `CHK("miso release", 1'b1, miso_oe_n_out)
        clock_byte;
        rd(STATCTL_ADDR, 8'h08, "deselected rx");
        sel <= 1'b1;
        clock_byte;
        rd(STATCTL_ADDR, 8'h88, "rx full");
        wr(CTRL_ADDR, 8'h08);
        settle(8);
        `CHK("owned off", 1'b0, pins_owned_out)
        `CHK("ss off", 1'b0, ss_owned_out)
        wr(CTRL_ADDR, 8'h22);
        settle(8);
        `CHK("ss master", 1'b0, ss_owned_out)
        `CHK("sclk drive", 1'b0, sclk_oe_n_out)
        sel <= 1'b0;
        settle(8);
        wr(STATCTL_ADDR, 8'h04);
        settle(8);
        `CHK("ss fault en", 1'b1, ss_owned_out)
        sel <= 1'b1;
        settle(8);
        sel <= 1'b0;
        rd(CTRL_ADDR, 8'h20, "fault ctrl");
        `CHK("fault release", 1'b0, pins_owned_out)
        settle(8);
        rd(STATCTL_ADDR, 8'h9C, "fault flag");
        break_in <= 1'b1;
        wr(CTRL_ADDR, 8'h20);
        rd(STATCTL_ADDR, 8'h9C, "break hold");
        break_in <= 1'b0;
        wr(CTRL_ADDR, 8'h20);
        rd(STATCTL_ADDR, 8'h8C, "second step");
        wr(BREAK_ADDR, 8'h80);
        wr(CTRL_ADDR, 8'h22);
        sel <= 1'b1;
        settle(8);
        sel <= 1'b0;
        rd(STATCTL_ADDR, 8'h9C, "fault again");
        break_in <= 1'b1;
        wr(CTRL_ADDR, 8'h20);
        break_in <= 1'b0;
        rd(STATCTL_ADDR, 8'h8C, "break clear");
        rst_in <= 1'b1;
        settle(2);
        rst_in <= 1'b0;
        rd(CTRL_ADDR, CTRL_RESET, "ctrl reset again");
        rd(STATCTL_ADDR, STAT_RESET, "stat reset again");
        `CHK("irq after reset", 1'b0, rx_irq)
        end_sim;
    end

    initial begin
        settle(20000);
        n_mismatch++;
        end_sim;
    end
endmodule : testbench
`default_nettype wire
